// File: src/woc_params.svh
`ifndef WOC_PARAMS_SVH
`define WOC_PARAMS_SVH
`define WOC_WORD_W 16
`define WOC_BYTE_W 8
`define WOC_NODE_CNT 64
`define WOC_NODE_W 6
`define WOC_ADDR_W 8
`define WOC_OFS_CTRL 8'h00
`define WOC_OFS_STAT 8'h01
`define WOC_OFS_NODE 8'h02
`define WOC_OFS_SEL 8'h03
`define WOC_OFS_STN_LO 8'h04
`define WOC_OFS_STN_HI 8'h05
`define WOC_CTRL_LINK_BIT 0
`define WOC_CTRL_RST 16'h0000
`endif

// File: src/woc_pkg.sv
package woc_pkg;
  typedef enum logic [1:0] {
    WOC_MODE_NONE = 2'b00,
    WOC_MODE_BIT = 2'b01,
    WOC_MODE_BYTE = 2'b10,
    WOC_MODE_BOTH = 2'b11
  } woc_mode_e;
  typedef struct packed {
    logic run_switch;
    logic simulation_setting;
    logic cpu_down;
    logic remote_io_stop_input;
    logic run_stop_contact;
  } woc_cpu_s;
  typedef struct packed {
    logic valid;
    logic to_line;
    logic [5:0] node;
    logic [7:0] addr;
    logic [15:0] data;
  } woc_word_s;
endpackage : woc_pkg

// File: src/woc_converter.sv
// Overview of operation
// - With no mode selected, words pass both ways unchanged.
// - Bit mode reverses bit order within each word, both directions.
// - Byte mode swaps upper and lower byte of each word, both ways.
// - Both selected: apply bit reversal and byte swap to each word.
// - Each node keeps its own bit select and byte select.
// - Inside the station format range, bit reversal is never applied.
// - Each word moves as one unit; multiword data is not coherent.
// - Without linkage, of the run and simulation switches, stop only when both are set.
// - With linkage, communicate only in run with normal setting.
// - Stop whenever the controller reports it has gone down.
// - Without linkage, stop while remote I/O stop input is asserted.
// - With linkage, stop while the run-stop contact is asserted.
`include "woc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module woc_converter #(
  parameter int NODES = `WOC_NODE_CNT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`WOC_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire woc_pkg::woc_cpu_s cpu_in,
  input wire woc_pkg::woc_word_s word_in,
  output woc_pkg::woc_word_s word_out,
  output logic comm_enable
);
  // Per-node selects: bit 0 bit reversal, bit 1 byte reversal.
  logic [1:0] sel_q [NODES];
  logic link_q;
  logic [5:0] node_ptr_q;
  logic [7:0] stn_lo_q;
  logic [7:0] stn_hi_q;
  logic [15:0] reg_rdata_q;
  woc_pkg::woc_word_s word_q;
  logic comm_q;

  function automatic logic [15:0] bit_rev(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = w[15-i];
    end
    return r;
  endfunction : bit_rev

  function automatic logic [15:0] convert(
    input logic [15:0] w,
    input logic do_bit,
    input logic do_byte
  );
    logic [15:0] t;
    t = do_bit ? bit_rev(w) : w;
    return do_byte ? {t[7:0], t[15:8]} : t;
  endfunction : convert

  // Bit reversal followed by a byte swap leaves each byte where it was, only
  // mirrored; the checks use this form so they do not lean on convert().
  function automatic logic [15:0] byte_mirror(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      r[i] = w[7-i];
      r[i+8] = w[15-i];
    end
    return r;
  endfunction : byte_mirror

  // Communication gating.
  wire normal_setting = ~cpu_in.simulation_setting;
  wire gate_free = ~(cpu_in.run_switch & cpu_in.simulation_setting)
    & ~cpu_in.remote_io_stop_input;
  wire gate_link = cpu_in.run_switch & normal_setting
    & ~cpu_in.run_stop_contact;
  wire comm_d = ~cpu_in.cpu_down & (link_q ? gate_link : gate_free);

  // Data path: selection is per node; station range masks bit reversal.
  wire [1:0] node_sel = sel_q[word_in.node];
  wire in_station = (word_in.addr >= stn_lo_q) && (word_in.addr <= stn_hi_q)
    && (stn_lo_q <= stn_hi_q);
  wire do_bit = node_sel[0] & ~in_station;
  wire do_byte = node_sel[1];
  wire [15:0] conv_data = convert(word_in.data, do_bit, do_byte);

  // Register decode.
  wire wr_ctrl = reg_wr && reg_addr == `WOC_OFS_CTRL;
  wire wr_node = reg_wr && reg_addr == `WOC_OFS_NODE;
  wire wr_sel = reg_wr && reg_addr == `WOC_OFS_SEL;
  wire wr_lo = reg_wr && reg_addr == `WOC_OFS_STN_LO;
  wire wr_hi = reg_wr && reg_addr == `WOC_OFS_STN_HI;
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `WOC_OFS_CTRL: rd_mux = {15'h0000, link_q};
      `WOC_OFS_STAT: rd_mux = {15'h0000, comm_q};
      `WOC_OFS_NODE: rd_mux = {10'h000, node_ptr_q};
      `WOC_OFS_SEL: rd_mux = {14'h0000, sel_q[node_ptr_q]};
      `WOC_OFS_STN_LO: rd_mux = {8'h00, stn_lo_q};
      `WOC_OFS_STN_HI: rd_mux = {8'h00, stn_hi_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      link_q <= 1'b0;
      node_ptr_q <= 6'h00;
      stn_lo_q <= 8'hff;
      stn_hi_q <= 8'h00;
      reg_rdata_q <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        link_q <= reg_wdata[`WOC_CTRL_LINK_BIT];
      end
      if (wr_node) begin
        node_ptr_q <= reg_wdata[5:0];
      end
      if (wr_lo) begin
        stn_lo_q <= reg_wdata[7:0];
      end
      if (wr_hi) begin
        stn_hi_q <= reg_wdata[7:0];
      end
      reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  for (genvar n = 0; n < NODES; n++) begin : g_sel
    always_ff @(posedge mclk) begin
      if (rst) begin
        sel_q[n] <= 2'b00;
      end else if (wr_sel && node_ptr_q == 6'(n)) begin
        sel_q[n] <= reg_wdata[1:0];
      end
    end
  end

  // The whole word is captured in one edge so it can never tear.
  always_ff @(posedge mclk) begin
    if (rst) begin
      word_q <= '0;
      comm_q <= 1'b0;
    end else begin
      comm_q <= comm_d;
      word_q.valid <= word_in.valid & comm_d;
      word_q.to_line <= word_in.to_line;
      word_q.node <= word_in.node;
      word_q.addr <= word_in.addr;
      word_q.data <= conv_data;
    end
  end

  assign word_out = word_q;
  assign reg_rdata = reg_rdata_q;
  assign comm_enable = comm_q;

  chk_bit_reverse: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid && comm_d && do_bit && !do_byte
    |=> word_out.data == bit_rev($past(word_in.data)))
    else $error("bit reversal wrong");
  chk_byte_swap: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid && comm_d && !do_bit && do_byte
    |=> word_out.data == {$past(word_in.data[7:0]),
      $past(word_in.data[15:8])})
    else $error("byte swap wrong");
  chk_pass_through: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid && comm_d && node_sel == 2'b00
    |=> word_out.data == $past(word_in.data))
    else $error("pass through changed data");
  chk_both_modes: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid && do_bit && do_byte
    |=> word_out.data == byte_mirror($past(word_in.data)))
    else $error("combined conversion wrong");
  chk_station_mask: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid && in_station && node_sel == 2'b01
    |=> word_out.data == $past(word_in.data))
    else $error("bit reversal inside station range");
  chk_sim_run_stop: assert property (@(posedge mclk) disable iff (rst)
    !link_q && cpu_in.run_switch && cpu_in.simulation_setting
    |=> !comm_enable)
    else $error("communicating in run with simulation");
  chk_link_gate: assert property (@(posedge mclk) disable iff (rst)
    link_q && !(cpu_in.run_switch && normal_setting) |=> !comm_enable)
    else $error("linked gate open outside run normal");
  chk_cpu_down: assert property (@(posedge mclk) disable iff (rst)
    cpu_in.cpu_down |=> !comm_enable && !word_out.valid)
    else $error("communicating with controller down");
  chk_rio_stop: assert property (@(posedge mclk) disable iff (rst)
    !link_q && cpu_in.remote_io_stop_input |=> !comm_enable)
    else $error("communicating during remote stop");
  chk_contact_stop: assert property (@(posedge mclk) disable iff (rst)
    link_q && cpu_in.run_stop_contact |=> !comm_enable)
    else $error("communicating during run-stop contact");
  chk_node_select: assert property (@(posedge mclk) disable iff (rst)
    wr_sel |=> sel_q[node_ptr_q] == $past(reg_wdata[1:0]))
    else $error("node select not stored");
  chk_word_whole: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid && comm_d |=> word_out.valid
    && word_out.node == $past(word_in.node))
    else $error("word not moved as a unit");

  // Building blocks for the steps of a read and of a word transfer.
  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_word_dropped;
    word_in.valid && !comm_d;
  endsequence
  sequence s_word_idle;
    !word_in.valid;
  endsequence

  // The free gate is rebuilt here from the switch levels, not from comm_d.
  chk_free_gate: assert property (@(posedge mclk) disable iff (rst)
    !link_q |=> comm_enable == $past(!cpu_in.cpu_down
    && !cpu_in.remote_io_stop_input
    && !(cpu_in.run_switch && cpu_in.simulation_setting)))
    else $error("unlinked gate differs from switch table");
  chk_linked_gate: assert property (@(posedge mclk) disable iff (rst)
    link_q |=> comm_enable == $past(cpu_in.run_switch
    && !cpu_in.simulation_setting && !cpu_in.cpu_down
    && !cpu_in.run_stop_contact))
    else $error("linked gate differs from switch table");
  chk_valid_drop: assert property (@(posedge mclk) disable iff (rst)
    s_word_dropped |=> !word_out.valid)
    else $error("word passed while communication stopped");
  chk_idle_word: assert property (@(posedge mclk) disable iff (rst)
    s_word_idle |=> !word_out.valid)
    else $error("word appeared from nothing");
  chk_word_fields: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid |=> word_out.addr == $past(word_in.addr)
    && word_out.to_line == $past(word_in.to_line))
    else $error("word fields split from data");
  chk_station_both: assert property (@(posedge mclk) disable iff (rst)
    word_in.valid && in_station && node_sel == 2'b11
    |=> word_out.data == {$past(word_in.data[7:0]),
    $past(word_in.data[15:8])})
    else $error("station range word not byte swapped only");
  chk_read_idle: assert property (@(posedge mclk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_read_ctrl: assert property (@(posedge mclk) disable iff (rst)
    s_read(`WOC_OFS_CTRL) |=> reg_rdata == {15'h0000, $past(link_q)})
    else $error("control read back wrong");
  chk_read_stat: assert property (@(posedge mclk) disable iff (rst)
    s_read(`WOC_OFS_STAT)
    |=> reg_rdata == {15'h0000, $past(comm_enable)})
    else $error("status read back wrong");
  chk_read_sel: assert property (@(posedge mclk) disable iff (rst)
    s_read(`WOC_OFS_SEL)
    |=> reg_rdata == {14'h0000, $past(sel_q[node_ptr_q])})
    else $error("select read back wrong");
  chk_read_unmapped: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && reg_addr > `WOC_OFS_STN_HI |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_link_store: assert property (@(posedge mclk) disable iff (rst)
    wr_ctrl |=> link_q == $past(reg_wdata[`WOC_CTRL_LINK_BIT]))
    else $error("linkage bit not stored");
  chk_ptr_store: assert property (@(posedge mclk) disable iff (rst)
    wr_node |=> node_ptr_q == $past(reg_wdata[5:0]))
    else $error("node pointer not stored");
  chk_range_lo: assert property (@(posedge mclk) disable iff (rst)
    wr_lo |=> stn_lo_q == $past(reg_wdata[7:0]))
    else $error("station low bound not stored");
  chk_range_hi: assert property (@(posedge mclk) disable iff (rst)
    wr_hi |=> stn_hi_q == $past(reg_wdata[7:0]))
    else $error("station high bound not stored");
  // Reset must leave the block silent, whatever the switches say.
  chk_reset_quiet: assert property (@(posedge mclk)
    rst |=> !comm_enable && !word_out.valid && reg_rdata == 16'h0000)
    else $error("outputs active after reset");
endmodule : woc_converter
`default_nettype wire

// File: testbench/woc_node_src.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the controller memory and the line nodes; when idle the
// word lines carry inverted junk so stale data is never mistaken for live.
module woc_node_src (
  input wire logic mclk,
  input wire logic go,
  input wire logic dir,
  input wire logic [5:0] node,
  input wire logic [7:0] addr,
  input wire logic [15:0] data,
  output woc_pkg::woc_word_s word
);
  always_ff @(posedge mclk) begin
    word <= go ? {1'b1, dir, node, addr, data} : {1'b0, ~{dir, node, addr, data}};
  end
endmodule : woc_node_src
`default_nettype wire

// File: testbench/tb_word_order_converter.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_word_order_converter;
  logic mclk, rst, reg_wr, reg_rd, go, dir, ce;
  logic [7:0] reg_addr, adr;
  logic [15:0] reg_wdata, reg_rdata, dat;
  logic [5:0] nod;
  logic [31:0] lf;
  woc_pkg::woc_cpu_s cpu_in;
  woc_pkg::woc_word_s win, wout;
  int errors, check_count, cyc, sel[64], lo, hi, lk;
  woc_node_src src (.mclk(mclk), .go(go), .dir(dir), .node(nod), .addr(adr),
    .data(dat), .word(win));
  woc_converter dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_in(cpu_in), .word_in(win), .word_out(wout),
    .comm_enable(ce));
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [15:0] cv(logic [15:0] d, int b, int y);
    logic [15:0] r;
    r = d;
    if (b) for (int i = 0; i < 16; i++) r[i] = d[15 - i];
    return y ? {r[7:0], r[15:8]} : r;
  endfunction : cv
  function automatic logic pm(logic [4:0] c, int l);
    return l ? (c[4] & !c[3] & !c[2] & !c[0]) : !(c[2] | c[1] | (c[4] & c[3]));
  endfunction : pm
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk) reg_wr <= 0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk) reg_rd <= 0;
    #1 `CHK("rdata", e, reg_rdata)
  endtask : rd
  // Sends one word from node n and checks it just after the edge on which the design takes it.
  task automatic sn(int n, logic [7:0] a);
    int s;
    s = sel[n] & ((a >= lo && a <= hi) ? 2 : 3);
    lf = nx(lf);
    @(posedge mclk) {go, nod, adr, dat, dir} <= {1'b1, 6'(n), a, lf[15:0], lf[16]};
    @(posedge mclk) go <= 0;
    @(posedge mclk) #1 `CHK("valid", pm(cpu_in, lk), wout.valid)
    if (pm(cpu_in, lk)) `CHK("data", cv(lf[15:0], s & 1, s & 2), wout.data)
    `CHK("comm", pm(cpu_in, lk), ce)
    `CHK("node", 6'(n), wout.node)
    `CHK("addr", a, wout.addr)
    `CHK("dir", lf[16], wout.to_line)
  endtask : sn
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge mclk) if (++cyc == 20000) begin
    errors++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, go, dir, reg_addr, reg_wdata, nod, adr, dat} = '0;
    {cpu_in, errors, check_count, cyc, lk, lo, hi} = 0;
    // Mirrors the empty station range that reset leaves in the design.
    lo = 255;
    lf = 32'h0000_e929;
    repeat (20) @(posedge mclk);
    rst <= 0;
    rd(8'h03, 16'h0000);
    rd(8'h3c, 16'h0000);
    foreach (sel[n]) sel[n] = 0;
    for (int n = 0; n < 64; n += 9) begin
      sel[n] = (n / 9) & 3;
      wr(8'h02, 16'(n));
      wr(8'h03, 16'(sel[n]));
      rd(8'h03, 16'(sel[n]));
    end
    for (int k = 0; k < 40; k++) sn((k * 27 % 8) * 9 % 64, 8'(k));
    lo = 12;
    hi = 14;
    wr(8'h04, 16'h000c);
    wr(8'h05, 16'h000e);
    for (int a = 11; a < 16; a++) sn(9, 8'(a));
    for (int a = 11; a < 16; a++) sn(27, 8'(a));
    for (lk = 0; lk < 2; lk++) begin
      wr(8'h00, 16'(lk));
      for (int c = 0; c < 32; c++) begin
        cpu_in <= 5'(c);
        sn(18, 8'h50);
        rd(8'h01, 16'(pm(5'(c), lk)));
      end
    end
    summarize();
  end
endmodule : tb_word_order_converter
`default_nettype wire
